// file: hw/pfcf_loop_filters.sv
// pfc voltage and current loop filters with fast loop control and modulator
`timescale 1ns/1ps
`include "pfcf_regs.svh"
module pfcf_loop_filters #(
   parameter int unsigned PWM_PERIOD   = 100,
   parameter int unsigned K_SHIFT      = 8,
   parameter int unsigned FAST_MAX_CYC = `PFCF_FAST_MAX_CYC
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_b,
   input  wire logic [15:0]                regAddr,
   input  wire logic                       regWrEn,
   input  wire logic [7:0]                 regWrData,
   output logic      [7:0]                 regRdData,
   input  wire logic [10:0]                refSetting,
   input  wire logic [10:0]                outputFeedbackSample,
   input  wire logic                       fbHalfValid,
   input  wire logic [9:0]                 fbFastSample,
   input  wire logic                       fbFastValid,
   input  wire logic [10:0]                rectifiedLineSample,
   input  wire logic [7:0]                 lineRms,
   input  wire logic                       lineRmsValid,
   input  wire logic [10:0]                currentSample,
   input  wire logic                       lineAboveThr,
   input  wire pfcf_pkg::pfcf_coefset_t    coefs,
   input  wire logic                       autoLineSel,
   input  wire logic                       manualHighLine,
   input  wire logic                       softStart,
   input  wire logic                       leadingEdge,
   input  wire logic [7:0]                 auxDelay,
   input  wire logic [7:0]                 auxWidth,
   output logic                            pwmMain,
   output logic                            auxSwitchOutput,
   output logic                            fastMode,
   output logic                            highLine,
   output logic      [11:0]                voltageErrorFilterOut
);
   logic [7:0]  pwmMinReg_r, fastCfgReg_r, hiThrReg_r, loThrReg_r, regRdData_r;
   logic        lineSync1_r, lineSync2_r, lineSync3_r, zcTick_r;
   logic [19:0] halfCnt_r, halfPeriod_r;
   logic [7:0]  lineRmsLat_r;
   logic        highLine_r, wantHigh;
   logic [3:0]  lineWait_r;
   logic [10:0] fbLat_r, errMag;
   logic [15:0] bandProd, bandLim;
   logic        outBand, fastAllowed, lockout_r, fastMode_r;
   pfcf_pkg::pfcf_fast_state_t state_r;
   logic [31:0] fastTimer_r;
   logic [2:0]  exitCnt_r;
   pfcf_pkg::pfcf_coef_t vCoefAct_r, iCoefAct_r;
   logic        vSample;
   logic [10:0] output_feedback_sample;
   logic signed [12:0] vErr, vErrPrev_r, iErr, iErrPrev_r;
   logic [11:0] voltageErrorFilterOut_r;
   logic [10:0] currentSetpoint_r;
   logic [30:0] irefNum, irefQuot;
   logic [15:0] rmsSq;
   logic [15:0] dutyCmd_r, dutyLim, dLat_r, pwmCnt_r, minOnCyc, minOffCyc;
   logic        pwmMain_r, auxOut_r;

   function automatic logic [15:0] pfcf_ns2cyc(input int unsigned ns);
      return 16'((ns + `PFCF_CLK_NS - 1) / `PFCF_CLK_NS);
   endfunction
   // y += k*b*(e - a/256*ePrev), k = 2^-K_SHIFT
   function automatic logic signed [39:0] pfcf_filt(input logic [15:0] acc, input logic signed [12:0] e,
                                                    input logic signed [12:0] ep, input pfcf_pkg::pfcf_coef_t c);
      logic signed [39:0] t;
      t = (40'(e) <<< `PFCF_ZERO_SCALE_SHIFT) - 40'(ep) * 40'($signed({1'b0, c.zero}));
      t = t * 40'($signed({1'b0, c.gain}));
      return 40'($signed({24'd0, acc})) + (t >>> (`PFCF_ZERO_SCALE_SHIFT + K_SHIFT));
   endfunction
   // clamping doubles as anti-windup for both integrators
   function automatic logic [15:0] pfcf_clamp(input logic signed [39:0] v, input logic [15:0] hi);
      return (v < 0) ? 16'h0000 : ((v > 40'($signed({24'd0, hi}))) ? hi : v[15:0]);
   endfunction
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pwmMinReg_r  <= `PFCF_RST_PWM_MIN;
         fastCfgReg_r <= `PFCF_RST_FAST_CFG;
         hiThrReg_r   <= `PFCF_RST_HI_THR;
         loThrReg_r   <= `PFCF_RST_LO_THR;
      end else if (regWrEn) begin
         case (regAddr)
            `PFCF_ADDR_PWM_MIN:  pwmMinReg_r  <= regWrData;
            `PFCF_ADDR_FAST_CFG: fastCfgReg_r <= regWrData;
            `PFCF_ADDR_HI_THR:   hiThrReg_r   <= regWrData;
            `PFCF_ADDR_LO_THR:   loThrReg_r   <= regWrData;
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         regRdData_r <= 8'h00;
      else begin
         case (regAddr)
            `PFCF_ADDR_PWM_MIN:  regRdData_r <= pwmMinReg_r;
            `PFCF_ADDR_FAST_CFG: regRdData_r <= fastCfgReg_r;
            `PFCF_ADDR_HI_THR:   regRdData_r <= hiThrReg_r;
            `PFCF_ADDR_LO_THR:   regRdData_r <= loThrReg_r;
            default:             regRdData_r <= 8'h00;
         endcase
      end
   end
   // zero crossing projected half a period after each falling crossing
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lineSync1_r  <= 1'b0;
         lineSync2_r  <= 1'b0;
         lineSync3_r  <= 1'b0;
         halfCnt_r    <= 20'h00000;
         halfPeriod_r <= 20'h00000;
         zcTick_r     <= 1'b0;
      end else begin
         lineSync1_r <= lineAboveThr;
         lineSync2_r <= lineSync1_r;
         lineSync3_r <= lineSync2_r;
         zcTick_r    <= 1'b0;
         if (lineSync3_r && !lineSync2_r) begin
            halfPeriod_r <= halfCnt_r;
            halfCnt_r    <= 20'h00000;
         end else begin
            if (!(&halfCnt_r))
               halfCnt_r <= halfCnt_r + 20'h00001;
            if (halfPeriod_r != 20'h00000 && halfCnt_r == {1'b0, halfPeriod_r[19:1]})
               zcTick_r <= 1'b1;
         end
      end
   end
   // line filter selection, hysteresis between the two thresholds
   always_comb begin
      if (!autoLineSel)
         wantHigh = manualHighLine;
      else if (lineRmsLat_r > hiThrReg_r)
         wantHigh = 1'b1;
      else if (lineRmsLat_r < loThrReg_r)
         wantHigh = 1'b0;
      else
         wantHigh = highLine_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lineRmsLat_r <= 8'h00;
         highLine_r   <= 1'b0;
         lineWait_r   <= 4'h0;
      end else begin
         if (lineRmsValid)
            lineRmsLat_r <= lineRms;
         if (wantHigh == highLine_r)
            lineWait_r <= 4'h0;
         else if (zcTick_r) begin
            // wait guards against one missing or distorted line cycle
            if (!autoLineSel || lineWait_r == 4'(`PFCF_LINE_WAIT_HALVES - 1)) begin
               highLine_r <= wantHigh;
               lineWait_r <= 4'h0;
            end else
               lineWait_r <= lineWait_r + 4'h1;
         end
      end
   end
   assign bandProd    = 16'(refSetting) * (`PFCF_BAND_BASE << fastCfgReg_r[`PFCF_FAST_BAND_FLD]);
   assign bandLim     = bandProd / `PFCF_BAND_DEN;
   assign errMag      = (refSetting >= fbLat_r) ? refSetting - fbLat_r : fbLat_r - refSetting;
   assign outBand     = {5'd0, errMag} > bandLim;
   assign fastAllowed = fastCfgReg_r[`PFCF_FAST_EN_BIT] || softStart;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_r     <= pfcf_pkg::FL_NORMAL;
         fastTimer_r <= 32'd0;
         exitCnt_r   <= 3'd0;
         lockout_r   <= 1'b0;
         fastMode_r  <= 1'b0;
      end else begin
         fastMode_r <= (state_r == pfcf_pkg::FL_FAST) || (state_r == pfcf_pkg::FL_EXIT);
         if (!outBand)
            lockout_r <= 1'b0;
         unique case (state_r)
            pfcf_pkg::FL_NORMAL: begin
               fastTimer_r <= 32'd0;
               if (outBand && fastAllowed && !lockout_r)
                  state_r <= pfcf_pkg::FL_ENTER;
            end
            pfcf_pkg::FL_ENTER: begin
               if (!outBand || !fastAllowed)
                  state_r <= pfcf_pkg::FL_NORMAL;
               else if (zcTick_r)
                  state_r <= pfcf_pkg::FL_FAST;
            end
            pfcf_pkg::FL_FAST, pfcf_pkg::FL_EXIT: begin
               fastTimer_r <= fastTimer_r + 32'd1;
               if (fastTimer_r == 32'(FAST_MAX_CYC - 1)) begin
                  state_r   <= pfcf_pkg::FL_NORMAL;
                  lockout_r <= 1'b1;
               end else if (state_r == pfcf_pkg::FL_FAST) begin
                  if (!outBand) begin
                     state_r   <= pfcf_pkg::FL_EXIT;
                     exitCnt_r <= 3'd0;
                  end
               end else if (outBand)
                  state_r <= pfcf_pkg::FL_FAST;
               else if (zcTick_r) begin
                  if (exitCnt_r == fastCfgReg_r[`PFCF_FAST_DLY_FLD])
                     state_r <= pfcf_pkg::FL_NORMAL;
                  else
                     exitCnt_r <= exitCnt_r + 3'd1;
               end
            end
         endcase
      end
   end
   // coefficients are only taken at reset, a zero crossing or a mode change
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         vCoefAct_r <= coefs.vNorm;
         iCoefAct_r <= coefs.iLow;
      end else if (zcTick_r || (fastMode_r != ((state_r == pfcf_pkg::FL_FAST) || (state_r == pfcf_pkg::FL_EXIT)))) begin
         vCoefAct_r <= ((state_r == pfcf_pkg::FL_FAST) || (state_r == pfcf_pkg::FL_EXIT)) ? coefs.vFast : coefs.vNorm;
         iCoefAct_r <= highLine_r ? coefs.iHigh : coefs.iLow;
      end
   end

   assign vSample = fastMode_r ? fbFastValid : fbHalfValid;
   assign output_feedback_sample     = fastMode_r ? {fbFastSample, 1'b0} : outputFeedbackSample;
   assign vErr    = $signed({2'b00, refSetting}) - $signed({2'b00, output_feedback_sample});

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         fbLat_r                 <= 11'h000;
         vErrPrev_r              <= 13'sh0000;
         voltageErrorFilterOut_r <= 12'h000;
      end else begin
         if (fbHalfValid)
            fbLat_r <= outputFeedbackSample;
         else if (fbFastValid)
            fbLat_r <= {fbFastSample, 1'b0};
         if (vSample) begin
            vErrPrev_r              <= vErr;
            voltageErrorFilterOut_r <= 12'(pfcf_clamp(pfcf_filt({4'h0, voltageErrorFilterOut_r}, vErr,
                                          vErrPrev_r, vCoefAct_r), 16'h0fff));
         end
      end
   end
   // 8 fractional bits keep the quotient usable at high line
   assign irefNum  = {8'(0), 23'(voltageErrorFilterOut_r * rectifiedLineSample)} << 8;
   assign rmsSq    = 16'(lineRmsLat_r * lineRmsLat_r);
   assign irefQuot = (rmsSq == 16'h0000) ? 31'd0 : irefNum / 31'(rmsSq);

   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         currentSetpoint_r <= 11'h000;
      else
         currentSetpoint_r <= (irefQuot > 31'h7ff) ? 11'h7ff : irefQuot[10:0];
   end
   assign iErr = $signed({2'b00, currentSetpoint_r}) - $signed({2'b00, currentSample});

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         iErrPrev_r <= 13'sh0000;
         dutyCmd_r  <= 16'h0000;
      end else if (pwmCnt_r == 16'h0000) begin
         iErrPrev_r <= iErr;
         dutyCmd_r  <= pfcf_clamp(pfcf_filt(dutyCmd_r, iErr, iErrPrev_r, iCoefAct_r), 16'(PWM_PERIOD));
      end
   end
   // 80 ns steps round up to whole 100 ns cycles
   assign minOnCyc  = pfcf_ns2cyc(`PFCF_MIN_STEP_NS * pwmMinReg_r[`PFCF_MINON_FLD]);
   assign minOffCyc = pfcf_ns2cyc(`PFCF_MINOFF_BASE_NS + `PFCF_MIN_STEP_NS * pwmMinReg_r[`PFCF_MINOFF_FLD]);

   always_comb begin
      dutyLim = dutyCmd_r;
      if (dutyLim > 16'(PWM_PERIOD) - minOffCyc)
         dutyLim = 16'(PWM_PERIOD) - minOffCyc;
      if (dutyLim < minOnCyc)
         dutyLim = 16'h0000;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pwmCnt_r  <= 16'h0000;
         dLat_r    <= 16'h0000;
         pwmMain_r <= 1'b0;
         auxOut_r  <= 1'b0;
      end else begin
         pwmCnt_r <= (pwmCnt_r == 16'(PWM_PERIOD - 1)) ? 16'h0000 : pwmCnt_r + 16'h0001;
         if (pwmCnt_r == 16'h0000)
            dLat_r <= dutyLim;
         if (leadingEdge)
            pwmMain_r <= pwmCnt_r >= 16'(PWM_PERIOD) - ((pwmCnt_r == 16'h0000) ? dutyLim : dLat_r);
         else
            pwmMain_r <= pwmCnt_r < ((pwmCnt_r == 16'h0000) ? dutyLim : dLat_r);
         auxOut_r <= (pwmCnt_r >= 16'(auxDelay)) && (pwmCnt_r < 16'(auxDelay) + 16'(auxWidth));
      end
   end
   assign regRdData             = regRdData_r;
   assign pwmMain               = pwmMain_r;
   assign auxSwitchOutput       = auxOut_r;
   assign fastMode              = fastMode_r;
   assign highLine              = highLine_r;
   assign voltageErrorFilterOut = voltageErrorFilterOut_r;
   logic [15:0] onRun_r;
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         onRun_r <= 16'h0000;
      else
         onRun_r <= pwmMain_r ? onRun_r + 16'h0001 : 16'h0000;
   end

   chk_fast_entry_zc: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(fastMode_r) && $past(state_r, 2) == pfcf_pkg::FL_ENTER |-> $past(zcTick_r, 2))
      else $error("fast loop entered away from a zero crossing");
   chk_fast_timeout: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == pfcf_pkg::FL_FAST && fastTimer_r == 32'(FAST_MAX_CYC - 1)) |=> state_r == pfcf_pkg::FL_NORMAL)
      else $error("fast loop outlived its time limit");
   chk_line_switch_zc: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(highLine_r) |-> $past(zcTick_r))
      else $error("line filter changed away from a zero crossing");
   chk_min_on_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(pwmMain_r) && $stable(pwmMinReg_r) |-> onRun_r >= minOnCyc)
      else $error("pulse narrower than minimum on time");
   chk_off_room: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pwmCnt_r == 16'h0001 && $stable(pwmMinReg_r) |-> 17'(dLat_r) + 17'(minOffCyc) <= 17'(PWM_PERIOD))
      else $error("duty leaves less than minimum off time");
   chk_reset_state: assert property (@(posedge clk_sys)
      !rst_b |=> state_r == pfcf_pkg::FL_NORMAL && !fastMode_r && voltageErrorFilterOut_r == 12'h000)
      else $error("loop not in normal cleared state after reset");
   chk_lead_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(pwmMain_r) && leadingEdge && $past(leadingEdge) |-> $past(pwmCnt_r) == 16'h0000)
      else $error("leading edge pulse ended mid period");
   chk_current_setpoint_no_rms: assert property (@(posedge clk_sys) disable iff (!rst_b)
      lineRmsLat_r == 8'h00 |=> currentSetpoint_r == 11'h000)
      else $error("current setpoint nonzero with zero rms");
   chk_normal_rate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(voltageErrorFilterOut_r) && !$past(fastMode_r) |-> $past(fbHalfValid))
      else $error("normal loop updated without half cycle sample");
   chk_fast_rate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(voltageErrorFilterOut_r) && $past(fastMode_r) |-> $past(fbFastValid))
      else $error("fast loop updated without fast sample");
endmodule

// file: hw/pfcf_pkg.sv
// types shared by the pfc loop filters
package pfcf_pkg;
   typedef struct packed {
      logic [7:0] zero;
      logic [7:0] gain;
   } pfcf_coef_t;
   typedef struct packed {
      pfcf_coef_t vNorm;
      pfcf_coef_t vFast;
      pfcf_coef_t iLow;
      pfcf_coef_t iHigh;
   } pfcf_coefset_t;
   typedef enum logic [1:0] {
      FL_NORMAL = 2'b00,
      FL_ENTER  = 2'b01,
      FL_FAST   = 2'b10,
      FL_EXIT   = 2'b11
   } pfcf_fast_state_t;
endpackage

// file: hw/pfcf_regs.svh
// register offsets, field positions, reset values and timing counts of the pfc loop filters
`ifndef PFCF_REGS_SVH
`define PFCF_REGS_SVH
`define PFCF_ADDR_PWM_MIN      16'hfe15
`define PFCF_ADDR_FAST_CFG     16'hfe24
`define PFCF_ADDR_HI_THR       16'hfe35
`define PFCF_ADDR_LO_THR       16'hfe36
`define PFCF_RST_PWM_MIN       8'h00
`define PFCF_RST_FAST_CFG      8'h00
`define PFCF_RST_HI_THR        8'ha0
`define PFCF_RST_LO_THR        8'h90
`define PFCF_MINOFF_FLD        3:0
`define PFCF_MINON_FLD         7:4
`define PFCF_FAST_EN_BIT       0
`define PFCF_FAST_BAND_FLD     2:1
`define PFCF_FAST_DLY_FLD      5:3
`define PFCF_CLK_NS            100
`define PFCF_MINOFF_BASE_NS    40
`define PFCF_MIN_STEP_NS       80
`define PFCF_FAST_MAX_MS       630
`define PFCF_FAST_MAX_CYC      ((`PFCF_FAST_MAX_MS * 1000000) / `PFCF_CLK_NS)
`define PFCF_ZERO_SCALE_SHIFT  8
`define PFCF_BAND_DEN          16'd200
`define PFCF_BAND_BASE         16'd3
`define PFCF_LINE_WAIT_HALVES  8
`endif

// file: verification/pfcf_loop_filters_bench.sv
// self-checking bench for the pfc loop filters
`timescale 1ns/1ps
`include "pfcf_regs.svh"
module pfcf_loop_filters_bench;
   localparam int FMAX = 2000;
   localparam int HUMP = 400;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic        regWrEn = 1'b0;
   logic [7:0]  regWrData = 8'h00;
   logic [7:0]  regRdData;
   logic [10:0] refSetting = 11'h3e8;
   logic [10:0] fbS = 11'h3e8;
   logic [10:0] rectified_line_sample;
   logic [10:0] curS;
   logic [7:0]  lineRms = 8'h80;
   logic        lineAboveThr, lineRmsValid, fbHalfValid, fbFastValid;
   logic        autoLineSel = 1'b0;
   logic        manualHighLine = 1'b0;
   logic        softStart = 1'b0;
   logic        leadingEdge = 1'b0;
   logic [7:0]  auxDelay = 8'h00;
   logic [7:0]  auxWidth = 8'h00;
   logic        pwmMain, auxSwitchOutput, fastMode, highLine;
   logic [11:0] voltage_error_filter_out;
   pfcf_pkg::pfcf_coefset_t coefs = {4{16'h0040}};
   int          num_errors = 0;
   int          samples_checked = 0;
   int          n;
   pfcf_loop_filters #(.FAST_MAX_CYC(FMAX)) i_pfcf_loop_filters (.clk_sys(clk_sys), .rst_b(rst_b),
      .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
      .refSetting(refSetting), .outputFeedbackSample(fbS), .fbHalfValid(fbHalfValid),
      .fbFastSample(fbS[10:1]), .fbFastValid(fbFastValid), .rectifiedLineSample(rectified_line_sample), .lineRms(lineRms),
      .lineRmsValid(lineRmsValid), .currentSample(curS), .lineAboveThr(lineAboveThr), .coefs(coefs),
      .autoLineSel(autoLineSel), .manualHighLine(manualHighLine), .softStart(softStart),
      .leadingEdge(leadingEdge), .auxDelay(auxDelay), .auxWidth(auxWidth), .pwmMain(pwmMain),
      .auxSwitchOutput(auxSwitchOutput), .fastMode(fastMode), .highLine(highLine),
      .voltageErrorFilterOut(voltage_error_filter_out));
   pfcf_stage_model i_pfcf_stage_model (.clk_sys(clk_sys), .pwmMain(pwmMain), .lineAboveThr(lineAboveThr),
      .rectifiedLineSample(rectified_line_sample), .lineRmsValid(lineRmsValid), .fbHalfValid(fbHalfValid),
      .fbFastValid(fbFastValid), .currentSample(curS));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      regAddr = a;
      cyc(1);
      d = regRdData;
   endtask
   // bounded wait for fastMode (sel 0) or highLine (sel 1) to reach lvl
   task automatic waitSig(input logic sel, input logic lvl, input int lim);
      n = 0;
      while (((sel ? highLine : fastMode) !== lvl) && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_regs;
      logic [15:0] a [4] = '{`PFCF_ADDR_PWM_MIN, `PFCF_ADDR_FAST_CFG, `PFCF_ADDR_HI_THR, `PFCF_ADDR_LO_THR};
      logic [7:0]  r [4] = '{`PFCF_RST_PWM_MIN, `PFCF_RST_FAST_CFG, `PFCF_RST_HI_THR, `PFCF_RST_LO_THR};
      logic [7:0]  d;
      for (int i = 0; i < 4; i++) begin
         rd(a[i], d);
         check("reset value", {8'h00, d}, {8'h00, r[i]});
         wr(a[i], 8'h5a ^ 8'(i));
         rd(a[i], d);
         check("readback", {8'h00, d}, {8'h00, 8'h5a ^ 8'(i)});
         wr(a[i], r[i]);
      end
      wr(16'hfe16, 8'hff);
      rd(16'hfe16, d);
      check("unmapped read", {8'h00, d}, 16'h0000);
      $display("t_regs done");
   endtask
   task automatic t_pwm;
      int run, mx, mn;
      logic [11:0] v0;
      refSetting = 11'h708;
      fbS = 11'h100;
      for (int e = 0; e < 2; e++) begin
         // edge mode only changes under reset, a live change would cut a pulse short
         rst_b = 1'b0;
         leadingEdge = e[0];
         cyc(4);
         rst_b = 1'b1;
         wr(`PFCF_ADDR_PWM_MIN, 8'hff);
         check("mid reset outputs", 16'({fastMode, highLine, pwmMain, voltage_error_filter_out}), 16'h0000);
         cyc(3000);
         // first run may be cut by the window start, so it starts far negative
         run = -9999;
         mx = 0;
         mn = 999;
         repeat (2000) begin
            cyc(1);
            if (pwmMain === 1'b1) run++;
            else begin
               if (run > 0) mn = run < mn ? run : mn;
               mx = run > mx ? run : mx;
               run = 0;
            end
         end
         // 1240 ns off and 1200 ns on, rounded up to 100 ns cycles
         check("longest pulse", 16'(mx <= 100 - 13 && mx > 0), 16'h0001);
         check("shortest pulse", 16'(mn >= 12), 16'h0001);
         check("fast off when disabled", 16'(fastMode), 16'h0000);
      end
      check("voltage filter up", 16'(voltage_error_filter_out > 0), 16'h0001);
      v0 = voltage_error_filter_out;
      refSetting = 11'h080;
      cyc(HUMP * 3);
      check("voltage filter down", 16'(voltage_error_filter_out < v0), 16'h0001);
      $display("t_pwm done");
   endtask
   task automatic t_aux;
      auxDelay = 8'h0a;
      auxWidth = 8'h05;
      n = 0;
      repeat (1000) begin
         cyc(1);
         if (auxSwitchOutput === 1'b1) n++;
      end
      check("aux high cycles", 16'(n), 16'h0032);
      $display("t_aux done");
   endtask
   task automatic t_fast;
      refSetting = 11'h3e8;
      fbS = 11'h3e8;
      wr(`PFCF_ADDR_FAST_CFG, 8'h01);
      cyc(HUMP * 2);
      check("in band", 16'(fastMode), 16'h0000);
      fbS = 11'h320;
      waitSig(1'b0, 1'b1, HUMP * 3);
      check("fast entry", 16'(n < HUMP * 3), 16'h0001);
      waitSig(1'b0, 1'b0, FMAX + 50);
      check("forced exit", 16'(n > FMAX - 20 && n < FMAX + 20), 16'h0001);
      cyc(HUMP * 2);
      check("no re-entry", 16'(fastMode), 16'h0000);
      fbS = 11'h3e8;
      wr(`PFCF_ADDR_FAST_CFG, 8'h18);
      cyc(HUMP);
      softStart = 1'b1;
      fbS = 11'h320;
      waitSig(1'b0, 1'b1, HUMP * 3);
      check("soft start fast", 16'(n < HUMP * 3), 16'h0001);
      fbS = 11'h3e8;
      waitSig(1'b0, 1'b0, HUMP * 6);
      check("exit delay", 16'(n > HUMP * 2 && n < HUMP * 6), 16'h0001);
      softStart = 1'b0;
      $display("t_fast done");
   endtask
   task automatic t_line;
      manualHighLine = 1'b1;
      waitSig(1'b1, 1'b1, HUMP * 3);
      check("manual line", 16'(n < HUMP * 3), 16'h0001);
      lineRms = 8'h60;
      autoLineSel = 1'b1;
      waitSig(1'b1, 1'b0, HUMP * 12);
      check("auto line wait", 16'(n > HUMP * 6 && n < HUMP * 10), 16'h0001);
      $display("t_line done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      #(100 * 60000);
      num_errors++;
      $display("watchdog expired");
      results();
   end
   initial begin
      cyc(8);
      rst_b = 1'b1;
      cyc(1);
      check("reset outputs", 16'({fastMode, highLine, pwmMain, voltage_error_filter_out}), 16'h0000);
      t_regs();
      t_pwm();
      t_aux();
      t_fast();
      t_line();
      results();
   end
endmodule

// file: verification/pfcf_stage_model.sv
// behavioural line sense and boost stage feeding the loop filters
`timescale 1ns/1ps
module pfcf_stage_model (
   input  wire logic        clk_sys,
   input  wire logic        pwmMain,
   output logic             lineAboveThr,
   output logic      [10:0] rectifiedLineSample,
   output logic             lineRmsValid,
   output logic             fbHalfValid,
   output logic             fbFastValid,
   output logic      [10:0] currentSample
);
   // line hump scaled down to 400 cycles, fast samples to 67, to keep runs short
   int ph = 0;
   int fc = 0;
   initial begin
      {lineAboveThr, lineRmsValid, fbHalfValid, fbFastValid} = 4'h0;
      rectifiedLineSample = 11'h000;
      currentSample = 11'h000;
   end
   always @(negedge clk_sys) begin
      ph = (ph + 1) % 400;
      fc = (fc + 1) % 67;
      lineAboveThr <= ph >= 50 && ph < 350;
      rectifiedLineSample <= 11'(ph < 200 ? ph * 5 : (400 - ph) * 5);
      lineRmsValid <= ph == 0;
      fbHalfValid <= ph == 200;
      fbFastValid <= fc == 0;
      // inductor current ramps while the switch is on, decays while off
      if (pwmMain && currentSample < 11'h0c8) currentSample <= currentSample + 11'h001;
      else if (!pwmMain && currentSample != 11'h000) currentSample <= currentSample - 11'h001;
   end
endmodule
